// ===== dcpp_cfg.svh
// register offsets, control bit positions and reset values for the channel progress block
`ifndef DCPP_CFG_SVH
`define DCPP_CFG_SVH
`define DCPP_OFF_SRC_LEN 8'h00
`define DCPP_OFF_SRC_PTR 8'h04
`define DCPP_OFF_DST_PTR 8'h08
`define DCPP_OFF_CELL_LEN 8'h0C
`define DCPP_OFF_CELL_PTR 8'h10
`define DCPP_OFF_PATTERN 8'h14
`define DCPP_OFF_CTRL 8'h18
`define DCPP_CTRL_EN_BIT 0
`define DCPP_CTRL_PAT_BIT 1
`define DCPP_CTRL_TRIG_BIT 2
`define DCPP_RST_PTR 16'h0000
`define DCPP_RST_PAT 8'h00
`endif

// ===== dcpp_pkg.sv
// types shared by the channel progress block
package dcpp_pkg;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } dcpp_beat_t;
    typedef enum logic [1:0] {
        DCPP_IDLE = 2'b00,
        DCPP_MOVE = 2'b01,
        DCPP_DONE = 2'b10
    } dcpp_state_t;
endpackage

// ===== dcpp_skid.sv
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module dcpp_skid (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire dcpp_pkg::dcpp_beat_t in_beat,
    output logic out_valid,
    input wire logic out_ready,
    output dcpp_pkg::dcpp_beat_t out_beat
);
    import dcpp_pkg::*;
    dcpp_beat_t mem_q [2];
    dcpp_beat_t mem_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic rd_q, rd_d, wr_q, wr_d;
    logic push, pop;
    assign in_ready = (cnt_q != 2'h2);
    assign out_valid = (cnt_q != 2'h0);
    assign out_beat = mem_q[rd_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb begin
        mem_d[0] = mem_q[0];
        mem_d[1] = mem_q[1];
        if (push) begin
            mem_d[wr_q] = in_beat;
        end
        wr_d = push ? ~wr_q : wr_q;
        rd_d = pop ? ~rd_q : rd_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= 2'h0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            mem_q[0] <= '0;
            mem_q[1] <= '0;
        end else begin
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
            mem_q[0] <= mem_d[0];
            mem_q[1] <= mem_d[1];
        end
    end
    chk_skid_no_overflow: assert property (@(posedge clk) disable iff (rst)
        cnt_q <= 2'h2) else $error("buffer count above two");
    chk_skid_no_drop: assert property (@(posedge clk) disable iff (rst)
        in_valid |-> in_ready) else $error("byte offered to a full buffer");
endmodule

// ===== dcpp_top.sv
// channel progress pointers, cell size and match pattern with byte mover
`timescale 1ns/1ns
`include "dcpp_cfg.svh"
// How it works
// - the source pointer reads back as a 16-bit count of bytes read, upper bits zero, zero at reset.
// - the destination pointer reads back as the 16-bit index of the next destination byte.
// - a pattern hit with pattern mode on clears the source pointer and the cell pointer.
// - each trigger moves cell-length bytes unless the source length or a pattern hit ends it sooner, where zero stands for 65536 bytes.
// - the cell pointer counts bytes moved in the current cell and clears to zero when the cell, the source or a pattern hit ends it.
// - the pattern byte is only looked at in pattern mode and its upper 24 bits read zero.
// - the source length register holds the 16-bit source buffer length in bytes.
module dcpp_top (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [7:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire logic TRIG,
    input wire logic SRC_VALID,
    output logic SRC_READY,
    input wire logic [7:0] SRC_DATA,
    output logic DST_VALID,
    input wire logic DST_READY,
    output logic [7:0] DST_DATA,
    output logic DST_LAST,
    output logic BUSY,
    output logic MATCHED
);
    import dcpp_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [15:0] src_len_q, src_len_d;
    logic [15:0] src_ptr_q, src_ptr_d;
    logic [15:0] dst_ptr_q, dst_ptr_d;
    logic [15:0] cell_len_q, cell_len_d;
    logic [15:0] cell_ptr_q, cell_ptr_d;
    logic [7:0] pattern_q, pattern_d;
    logic en_q, en_d, pat_mode_q, pat_mode_d;
    logic [31:0] rdata_q, rdata_d;
    logic matched_q, matched_d;
    logic src_ready_q, src_ready_d;
    dcpp_state_t state_q, state_d;

    logic buf_in_ready, buf_out_valid;
    dcpp_beat_t buf_in, buf_out;
    logic take, hit, cell_end, src_end;
    logic buf_pop, dst_load;
    logic dst_valid_d, dst_last_d;
    logic [7:0] dst_data_d;

    function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
        sel = (a == off);
    endfunction

    // ****************************************
    // data path
    // ****************************************
    assign take = (state_q == DCPP_MOVE) && SRC_VALID && src_ready_q;
    // pattern byte ignored outside pattern mode
    assign hit = take && pat_mode_q && (SRC_DATA == pattern_q);
    // zero length wraps so that 65536 bytes are moved
    assign cell_end = ((cell_ptr_q + 16'h0001) == cell_len_q);
    assign src_end = ((src_ptr_q + 16'h0001) == src_len_q);
    assign buf_in.data = SRC_DATA;
    assign buf_in.last = hit || src_end;

    dcpp_skid u_buf (
        .clk(CLK),
        .rst(RST),
        .in_valid(take),
        .in_ready(buf_in_ready),
        .in_beat(buf_in),
        .out_valid(buf_out_valid),
        .out_ready(dst_load),
        .out_beat(buf_out)
    );

    // ****************************************
    // output stage
    // ****************************************
    // head moves on only when the output register is empty or consumed
    assign dst_load = !DST_VALID || DST_READY;
    assign buf_pop = buf_out_valid && dst_load;
    always_comb begin
        dst_valid_d = DST_VALID;
        dst_data_d = DST_DATA;
        dst_last_d = DST_LAST;
        if (dst_load) begin
            dst_valid_d = buf_out_valid;
            dst_data_d = buf_out.data;
            dst_last_d = buf_out.last;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        src_len_d = src_len_q;
        cell_len_d = cell_len_q;
        pattern_d = pattern_q;
        en_d = en_q;
        pat_mode_d = pat_mode_q;
        src_ptr_d = src_ptr_q;
        dst_ptr_d = dst_ptr_q;
        cell_ptr_d = cell_ptr_q;
        state_d = state_q;
        matched_d = matched_q;
        rdata_d = 32'h0000_0000;
        if (WR) begin
            if (sel(ADDR, `DCPP_OFF_SRC_LEN)) src_len_d = WDATA[15:0];
            if (sel(ADDR, `DCPP_OFF_CELL_LEN)) cell_len_d = WDATA[15:0];
            if (sel(ADDR, `DCPP_OFF_PATTERN)) pattern_d = WDATA[7:0];
            if (sel(ADDR, `DCPP_OFF_CTRL)) begin
                en_d = WDATA[`DCPP_CTRL_EN_BIT];
                pat_mode_d = WDATA[`DCPP_CTRL_PAT_BIT];
                if (WDATA[`DCPP_CTRL_EN_BIT]) begin
                    src_ptr_d = `DCPP_RST_PTR;
                    dst_ptr_d = `DCPP_RST_PTR;
                    cell_ptr_d = `DCPP_RST_PTR;
                    matched_d = 1'b0;
                    state_d = DCPP_IDLE;
                end
            end
        end
        if (RD) begin
            case (ADDR)
                `DCPP_OFF_SRC_LEN: rdata_d = {16'h0000, src_len_q};
                `DCPP_OFF_SRC_PTR: rdata_d = {16'h0000, src_ptr_q};
                `DCPP_OFF_DST_PTR: rdata_d = {16'h0000, dst_ptr_q};
                `DCPP_OFF_CELL_LEN: rdata_d = {16'h0000, cell_len_q};
                `DCPP_OFF_CELL_PTR: rdata_d = {16'h0000, cell_ptr_q};
                `DCPP_OFF_PATTERN: rdata_d = {24'h000000, pattern_q};
                `DCPP_OFF_CTRL: rdata_d = {29'h0, (state_q != DCPP_IDLE), pat_mode_q, en_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        case (state_q)
            DCPP_IDLE: begin
                if (en_q && TRIG) state_d = DCPP_MOVE;
            end
            DCPP_MOVE: begin
                if (take) begin
                    src_ptr_d = src_ptr_q + 16'h0001;
                    dst_ptr_d = dst_ptr_q + 16'h0001;
                    cell_ptr_d = cell_ptr_q + 16'h0001;
                    if (hit) begin
                        src_ptr_d = `DCPP_RST_PTR;
                        cell_ptr_d = `DCPP_RST_PTR;
                        matched_d = 1'b1;
                        state_d = DCPP_DONE;
                    end else if (src_end) begin
                        cell_ptr_d = `DCPP_RST_PTR;
                        state_d = DCPP_DONE;
                    end else if (cell_end) begin
                        cell_ptr_d = `DCPP_RST_PTR;
                        state_d = DCPP_IDLE;
                    end
                end
            end
            DCPP_DONE: begin
                en_d = 1'b0;
                state_d = DCPP_IDLE;
            end
            default: state_d = DCPP_IDLE;
        endcase
        // stall source one cycle ahead so the buffer never overflows
        src_ready_d = (state_d == DCPP_MOVE) && buf_in_ready && !(take && !buf_pop && buf_out_valid);
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            src_len_q <= 16'h0000;
            src_ptr_q <= `DCPP_RST_PTR;
            dst_ptr_q <= `DCPP_RST_PTR;
            cell_len_q <= 16'h0000;
            cell_ptr_q <= `DCPP_RST_PTR;
            pattern_q <= `DCPP_RST_PAT;
            en_q <= 1'b0;
            pat_mode_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            matched_q <= 1'b0;
            src_ready_q <= 1'b0;
            state_q <= DCPP_IDLE;
            DST_VALID <= 1'b0;
            DST_DATA <= 8'h00;
            DST_LAST <= 1'b0;
            BUSY <= 1'b0;
        end else begin
            src_len_q <= src_len_d;
            src_ptr_q <= src_ptr_d;
            dst_ptr_q <= dst_ptr_d;
            cell_len_q <= cell_len_d;
            cell_ptr_q <= cell_ptr_d;
            pattern_q <= pattern_d;
            en_q <= en_d;
            pat_mode_q <= pat_mode_d;
            rdata_q <= rdata_d;
            matched_q <= matched_d;
            src_ready_q <= src_ready_d;
            state_q <= state_d;
            DST_VALID <= dst_valid_d;
            DST_DATA <= dst_data_d;
            DST_LAST <= dst_last_d;
            BUSY <= (state_d != DCPP_IDLE);
        end
    end

    assign RDATA = rdata_q;
    assign SRC_READY = src_ready_q;
    assign MATCHED = matched_q;

    // ****************************************
    // register checks
    // ****************************************
    chk_src_upper_zero: assert property (@(posedge CLK) disable iff (RST)
        $past(RD) && $past(ADDR) == `DCPP_OFF_SRC_PTR |-> RDATA[31:16] == 16'h0000)
        else $error("source pointer upper bits not zero");
    chk_dst_upper_zero: assert property (@(posedge CLK) disable iff (RST)
        $past(RD) && $past(ADDR) == `DCPP_OFF_DST_PTR |-> RDATA[31:16] == 16'h0000)
        else $error("destination pointer upper bits not zero");
    chk_cell_upper_zero: assert property (@(posedge CLK) disable iff (RST)
        $past(RD) && $past(ADDR) == `DCPP_OFF_CELL_PTR |-> RDATA[31:16] == 16'h0000)
        else $error("cell pointer upper bits not zero");
    chk_pattern_upper: assert property (@(posedge CLK) disable iff (RST)
        $past(RD) && $past(ADDR) == `DCPP_OFF_PATTERN |-> RDATA[31:8] == 24'h000000)
        else $error("pattern upper bits not zero");
    chk_rdata_quiet: assert property (@(posedge CLK) disable iff (RST)
        !$past(RD) |-> RDATA == 32'h0000_0000)
        else $error("read data not zero outside a read");
    chk_src_len_store: assert property (@(posedge CLK) disable iff (RST)
        WR && ADDR == `DCPP_OFF_SRC_LEN |=> src_len_q == $past(WDATA[15:0]))
        else $error("source length not stored");
    chk_cell_len_store: assert property (@(posedge CLK) disable iff (RST)
        WR && ADDR == `DCPP_OFF_CELL_LEN |=> cell_len_q == $past(WDATA[15:0]))
        else $error("cell length not stored");
    chk_pattern_store: assert property (@(posedge CLK) disable iff (RST)
        WR && ADDR == `DCPP_OFF_PATTERN |=> pattern_q == $past(WDATA[7:0]))
        else $error("pattern byte not stored");
    chk_ptr_read_only: assert property (@(posedge CLK) disable iff (RST)
        WR && ADDR == `DCPP_OFF_SRC_PTR && state_q == DCPP_IDLE |=> $stable(src_ptr_q))
        else $error("source pointer changed by a write");

    // ****************************************
    // transfer checks
    // ****************************************
    chk_dst_step: assert property (@(posedge CLK) disable iff (RST)
        take && !WR |=> dst_ptr_q == $past(dst_ptr_q) + 16'h0001)
        else $error("destination pointer did not advance");
    chk_match_clear: assert property (@(posedge CLK) disable iff (RST)
        hit && !WR |=> src_ptr_q == 16'h0000 && cell_ptr_q == 16'h0000)
        else $error("pointers not cleared on match");
    chk_match_sticky: assert property (@(posedge CLK) disable iff (RST)
        hit |=> MATCHED)
        else $error("match flag not set on match");
    chk_match_stop: assert property (@(posedge CLK) disable iff (RST)
        hit && !WR |=> state_q == DCPP_DONE)
        else $error("transfer did not end on match");
    chk_cell_wrap: assert property (@(posedge CLK) disable iff (RST)
        take && cell_end && !hit && !src_end && !WR |=> state_q == DCPP_IDLE)
        else $error("cell did not end at cell length");
    chk_cell_count: assert property (@(posedge CLK) disable iff (RST)
        take && !cell_end && !hit && !src_end && !WR
        |=> cell_ptr_q == $past(cell_ptr_q) + 16'h0001)
        else $error("cell pointer did not count");
    chk_trig_fresh: assert property (@(posedge CLK) disable iff (RST)
        state_q == DCPP_IDLE && en_q && TRIG && !WR |=> cell_ptr_q == 16'h0000)
        else $error("cell pointer not zero at trigger");
    chk_no_hit_off: assert property (@(posedge CLK) disable iff (RST)
        !pat_mode_q |-> !hit)
        else $error("match seen outside pattern mode");
    chk_src_end_stop: assert property (@(posedge CLK) disable iff (RST)
        take && src_end && !hit && !WR |=> state_q == DCPP_DONE)
        else $error("transfer did not end at source length");
    chk_cell_clear: assert property (@(posedge CLK) disable iff (RST)
        take && cell_end && !WR |=> cell_ptr_q == 16'h0000)
        else $error("cell pointer not cleared at cell end");
    chk_done_disable: assert property (@(posedge CLK) disable iff (RST)
        state_q == DCPP_DONE |=> !en_q)
        else $error("enable not cleared at transfer end");
    chk_busy_state: assert property (@(posedge CLK) disable iff (RST)
        BUSY == (state_q != DCPP_IDLE))
        else $error("busy flag does not follow the channel");
    chk_dst_hold: assert property (@(posedge CLK) disable iff (RST)
        DST_VALID && !DST_READY |=> DST_VALID && $stable(DST_DATA) && $stable(DST_LAST))
        else $error("output byte dropped during stall");
    chk_dst_no_repeat: assert property (@(posedge CLK) disable iff (RST)
        DST_VALID && DST_READY && !buf_out_valid |=> !DST_VALID)
        else $error("output byte offered twice");
    chk_no_lost_byte: assert property (@(posedge CLK) disable iff (RST)
        take |-> buf_in_ready)
        else $error("source byte taken with no room");

    cov_match: cover property (@(posedge CLK) disable iff (RST) hit);
    cov_cell_end: cover property (@(posedge CLK) disable iff (RST) take && cell_end);
    cov_stall: cover property (@(posedge CLK) disable iff (RST) DST_VALID && !DST_READY);
    cov_src_end: cover property (@(posedge CLK) disable iff (RST) take && src_end);
    cov_src_stall: cover property (@(posedge CLK) disable iff (RST)
        state_q == DCPP_MOVE && SRC_VALID && !SRC_READY);
endmodule

// ===== dcpp_far.sv
// far-side model: source byte stream and destination byte sink
`timescale 1ns/1ns
module dcpp_far (
    input wire logic clk,
    input wire logic rst,
    input wire logic go,
    input wire logic stall,
    output logic src_valid,
    input wire logic src_ready,
    output logic [7:0] src_data,
    input wire logic dst_valid,
    output logic dst_ready,
    input wire logic [7:0] dst_data,
    input wire logic dst_last,
    output logic [15:0] rx_cnt,
    output logic [7:0] rx_data,
    output logic rx_last,
    output logic [7:0] rx_bad
);
    logic [7:0] cur;
    assign cur = (src_valid && src_ready) ? src_data + 8'h01 : src_data;
    always_ff @(posedge clk) begin
        if (rst) begin
            src_valid <= 1'b0;
            src_data <= 8'hFF;
            dst_ready <= 1'b0;
            rx_cnt <= 16'h0000;
            rx_data <= 8'h00;
            rx_last <= 1'b0;
            rx_bad <= 8'h00;
        end else begin
            src_valid <= go;
            // released data toggles every cycle
            src_data <= go ? (src_valid ? cur : 8'h00) : ~src_data;
            dst_ready <= !stall;
            if (dst_valid && dst_ready) begin
                rx_cnt <= rx_cnt + 16'h0001;
                rx_data <= dst_data;
                rx_last <= dst_last;
                // bytes must arrive once each, in stream order
                if (dst_data != rx_cnt[7:0]) rx_bad <= rx_bad + 8'h01;
            end
        end
    end
endmodule

// ===== tb.sv
// self-checking bench for the channel progress block
`timescale 1ns/1ns
`include "dcpp_cfg.svh"
module tb;
    import dcpp_pkg::*;
    logic CLK = 1'b0;
    logic RST = 1'b1;
    logic [7:0] ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic TRIG = 1'b0;
    logic go = 1'b0;
    logic stall = 1'b0;
    logic [31:0] RDATA;
    logic SRC_VALID, SRC_READY, DST_VALID, DST_READY, DST_LAST, BUSY, MATCHED;
    logic [7:0] SRC_DATA, DST_DATA;
    logic [15:0] rx_cnt;
    logic [7:0] rx_data, rx_bad;
    logic rx_last;
    int error_cnt = 0;
    int samples_checked = 0;
    always #4 CLK = ~CLK;
    dcpp_top dcpp_top_inst (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .TRIG(TRIG), .SRC_VALID(SRC_VALID), .SRC_READY(SRC_READY),
        .SRC_DATA(SRC_DATA), .DST_VALID(DST_VALID), .DST_READY(DST_READY),
        .DST_DATA(DST_DATA), .DST_LAST(DST_LAST), .BUSY(BUSY), .MATCHED(MATCHED));
    dcpp_far dcpp_far_inst (.clk(CLK), .rst(RST), .go(go), .stall(stall),
        .src_valid(SRC_VALID), .src_ready(SRC_READY), .src_data(SRC_DATA),
        .dst_valid(DST_VALID), .dst_ready(DST_READY), .dst_data(DST_DATA), .dst_last(DST_LAST),
        .rx_cnt(rx_cnt), .rx_data(rx_data), .rx_last(rx_last), .rx_bad(rx_bad));
    // ****************
    // shared tasks
    // ****************
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK) begin WR <= 1'b1; ADDR <= a; WDATA <= d; end
        @(posedge CLK) WR <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge CLK) begin RD <= 1'b1; ADDR <= a; end
        @(posedge CLK) RD <= 1'b0;
        #1 d = RDATA;
    endtask
    task automatic poll(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        for (int i = 0; i < 200; i++) begin
            rd(a, d);
            if (d === exp) break;
        end
        chk(d, exp);
        if (d !== exp) results();
    endtask
    task automatic pulse_trig();
        @(posedge CLK) TRIG <= 1'b1;
        @(posedge CLK) TRIG <= 1'b0;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_reset();
        logic [31:0] d;
        for (int a = 0; a <= 8'h18; a += 4) begin
            rd(a[7:0], d);
            chk(d, 32'h0);
        end
        rd(8'h40, d);
        chk(d, 32'h0);
    endtask
    task automatic t_regs();
        logic [31:0] d;
        wr(`DCPP_OFF_CELL_LEN, 32'hFFFF_1234);
        rd(`DCPP_OFF_CELL_LEN, d);
        chk(d, 32'h0000_1234);
        wr(`DCPP_OFF_PATTERN, 32'hFFFF_FFA5);
        rd(`DCPP_OFF_PATTERN, d);
        chk(d, 32'h0000_00A5);
        wr(`DCPP_OFF_SRC_LEN, 32'hFFFF_FFFF);
        rd(`DCPP_OFF_SRC_LEN, d);
        chk(d, 32'h0000_FFFF);
        wr(`DCPP_OFF_SRC_PTR, 32'h0000_0055);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(`DCPP_OFF_SRC_PTR, d);
        chk(d, 32'h0);
    endtask
    task automatic t_cells();
        logic [31:0] d;
        wr(`DCPP_OFF_SRC_LEN, 32'h0);
        wr(`DCPP_OFF_CELL_LEN, 32'h4);
        wr(`DCPP_OFF_PATTERN, 32'h2);
        stall <= 1'b1;
        wr(`DCPP_OFF_CTRL, 32'h1);
        pulse_trig();
        repeat (12) @(posedge CLK);
        #1 chk({31'h0, SRC_READY}, 32'h0);
        chk({31'h0, BUSY}, 32'h1);
        rd(`DCPP_OFF_CTRL, d);
        chk(d, 32'h5);
        stall <= 1'b0;
        poll(`DCPP_OFF_SRC_PTR, 32'h4);
        poll(`DCPP_OFF_CELL_PTR, 32'h0);
        poll(`DCPP_OFF_DST_PTR, 32'h4);
        chk({31'h0, MATCHED}, 32'h0);
        chk({31'h0, BUSY}, 32'h0);
        pulse_trig();
        poll(`DCPP_OFF_SRC_PTR, 32'h8);
        poll(`DCPP_OFF_DST_PTR, 32'h8);
        chk({16'h0, rx_cnt}, 32'h8);
        chk({24'h0, rx_data}, 32'h7);
        chk({31'h0, rx_last}, 32'h0);
        chk({24'h0, rx_bad}, 32'h0);
    endtask
    task automatic t_match();
        logic [31:0] d;
        wr(`DCPP_OFF_CELL_LEN, 32'h10);
        wr(`DCPP_OFF_PATTERN, 32'h0A);
        wr(`DCPP_OFF_CTRL, 32'h3);
        pulse_trig();
        for (int i = 0; i < 100 && MATCHED !== 1'b1; i++) begin
            @(posedge CLK);
            #1;
        end
        chk({31'h0, MATCHED}, 32'h1);
        poll(`DCPP_OFF_SRC_PTR, 32'h0);
        poll(`DCPP_OFF_CELL_PTR, 32'h0);
        poll(`DCPP_OFF_DST_PTR, 32'h3);
        rd(`DCPP_OFF_CTRL, d);
        chk(d, 32'h2);
        chk({16'h0, rx_cnt}, 32'hB);
        chk({24'h0, rx_data}, 32'hA);
        chk({31'h0, rx_last}, 32'h1);
        chk({24'h0, rx_bad}, 32'h0);
    endtask
    task automatic t_srcend();
        wr(`DCPP_OFF_SRC_LEN, 32'h3);
        wr(`DCPP_OFF_CTRL, 32'h1);
        pulse_trig();
        poll(`DCPP_OFF_SRC_PTR, 32'h3);
        poll(`DCPP_OFF_CTRL, 32'h0);
        poll(`DCPP_OFF_CELL_PTR, 32'h0);
        chk({31'h0, MATCHED}, 32'h0);
        chk({16'h0, rx_cnt}, 32'hE);
        chk({24'h0, rx_data}, 32'hD);
        chk({31'h0, rx_last}, 32'h1);
        chk({24'h0, rx_bad}, 32'h0);
    endtask
    initial begin
        repeat (20) @(posedge CLK);
        RST <= 1'b0;
        go <= 1'b1;
        t_reset();
        t_regs();
        t_cells();
        t_match();
        t_srcend();
        results();
    end
endmodule
